//--- hw/fifo_mailbox_pkg.sv
// Shared constants, types and helper functions of the mailbox FIFO.
// Assumes nothing of its surroundings; included by package name only.
package fifo_mailbox_pkg;

    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int ADDR_W = 6;
    localparam int PTR_W = 7;
    localparam logic [PTR_W-1:0] FIFO_DEPTH = 7'h40;
    localparam logic [4:0] OFFSET_CODE_00 = 5'h04;
    localparam logic [4:0] OFFSET_CODE_01 = 5'h08;
    localparam logic [4:0] OFFSET_CODE_10 = 5'h0C;
    localparam logic [4:0] OFFSET_CODE_11 = 5'h10;
    localparam logic [2:0] OFFSET_LOAD_WAIT = 3'h5;
    localparam logic [1:0] READY_ALL = 2'h3;

    // One port's pins after sampling.
    typedef struct packed {
        logic clock;
        logic chip_select_n;
        logic write_not_read;
        logic enable;
        logic mailbox_select;
        logic parity_gen_select;
        logic odd_even;
        logic [DATA_W-1:0] data;
    } port_in_t;

    function automatic logic [PTR_W-1:0] bin_to_gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] gray_to_bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = '0;
        for (int i = PTR_W - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
        end
        return b;
    endfunction

    // Replaces the top bit of every lane with parity of its low eight bits.
    function automatic logic [DATA_W-1:0] gen_parity(input logic [DATA_W-1:0] d,
                                                      input logic odd);
        logic [DATA_W-1:0] r;
        r = d;
        for (int l = 0; l < LANES; l++) begin
            r[l*LANE_W+LANE_W-1] = (^d[l*LANE_W +: LANE_W-1]) ^ odd;
        end
        return r;
    endfunction

endpackage

//--- hw/pin_sampler.sv
// Three-stage sampler for a bundle of pins.
// Assumes the bundle changes asynchronously to clk; output updates when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module pin_sampler #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] stable
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pins;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stable <= '0;
        end else if (stage2 == stage3) begin
            stable <= stage3;
        end
    end

endmodule // pin_sampler
`default_nettype wire

//--- hw/fifo_mailbox.sv
// Mailbox FIFO: 64 words from port A to port B, two mailboxes, parity check.
// Assumes both port clocks are pins sampled by clk, well slower than clk.
`timescale 1ns/100ps
`default_nettype none
module fifo_mailbox (
    input wire logic clk,
    input wire logic nrst,
    input wire logic port_a_clock,
    input wire logic port_a_chip_select_n,
    input wire logic port_a_write_not_read,
    input wire logic port_a_enable,
    input wire logic port_a_mailbox_select,
    input wire logic port_a_parity_gen_select,
    input wire logic [fifo_mailbox_pkg::DATA_W-1:0] port_a_data_in,
    output logic [fifo_mailbox_pkg::DATA_W-1:0] port_a_data_out,
    output logic port_a_data_oe_n,
    input wire logic port_b_clock,
    input wire logic port_b_chip_select_n,
    input wire logic port_b_write_not_read,
    input wire logic port_b_enable,
    input wire logic port_b_mailbox_select,
    input wire logic port_b_parity_gen_select,
    input wire logic [fifo_mailbox_pkg::DATA_W-1:0] port_b_data_in,
    output logic [fifo_mailbox_pkg::DATA_W-1:0] port_b_data_out,
    output logic port_b_data_oe_n,
    input wire logic odd_even,
    input wire logic offset_select_lsb,
    input wire logic offset_select_msb,
    output logic full_n,
    output logic almost_full_n,
    output logic empty_n,
    output logic almost_empty_n,
    output logic a_to_b_mailbox_flag_n,
    output logic b_to_a_mailbox_flag_n,
    output logic port_a_parity_error_n,
    output logic port_b_parity_error_n
);

    localparam int DW = fifo_mailbox_pkg::DATA_W;
    localparam int PW = fifo_mailbox_pkg::PTR_W;
    localparam int AW = fifo_mailbox_pkg::ADDR_W;

    // ----------------------------------------------------------------
    // Pin sampling and port edge detection
    // ----------------------------------------------------------------
    fifo_mailbox_pkg::port_in_t a_pins;
    fifo_mailbox_pkg::port_in_t b_pins;
    fifo_mailbox_pkg::port_in_t a_in;
    fifo_mailbox_pkg::port_in_t b_in;
    logic [1:0] offset_pins;
    logic [1:0] offset_in;
    logic a_clock_prev;
    logic b_clock_prev;
    logic a_edge;
    logic b_edge;

    assign a_pins = '{clock: port_a_clock, chip_select_n: port_a_chip_select_n,
                      write_not_read: port_a_write_not_read, enable: port_a_enable,
                      mailbox_select: port_a_mailbox_select,
                      parity_gen_select: port_a_parity_gen_select,
                      odd_even: odd_even, data: port_a_data_in};
    assign b_pins = '{clock: port_b_clock, chip_select_n: port_b_chip_select_n,
                      write_not_read: port_b_write_not_read, enable: port_b_enable,
                      mailbox_select: port_b_mailbox_select,
                      parity_gen_select: port_b_parity_gen_select,
                      odd_even: odd_even, data: port_b_data_in};
    assign offset_pins = {offset_select_msb, offset_select_lsb};

    pin_sampler #(.WIDTH($bits(fifo_mailbox_pkg::port_in_t))) a_sampler (
        .clk(clk), .nrst(nrst), .pins(a_pins), .stable(a_in));
    pin_sampler #(.WIDTH($bits(fifo_mailbox_pkg::port_in_t))) b_sampler (
        .clk(clk), .nrst(nrst), .pins(b_pins), .stable(b_in));
    pin_sampler #(.WIDTH(2)) offset_sampler (
        .clk(clk), .nrst(nrst), .pins(offset_pins), .stable(offset_in));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_clock_prev <= 1'b0;
            b_clock_prev <= 1'b0;
        end else begin
            a_clock_prev <= a_in.clock;
            b_clock_prev <= b_in.clock;
        end
    end

    assign a_edge = a_in.clock & ~a_clock_prev;
    assign b_edge = b_in.clock & ~b_clock_prev;

    // ----------------------------------------------------------------
    // Port operation decode
    // ----------------------------------------------------------------
    logic a_sel_wr;
    logic a_sel_rd;
    logic b_sel_wr;
    logic b_sel_rd;
    logic fifo_wr;
    logic fifo_rd;
    logic a_mbox_wr;
    logic b_mbox_wr;
    logic a_mbox_rd;
    logic b_mbox_rd;
    logic a_gen_setup;
    logic b_gen_setup;

    assign a_sel_wr = !a_in.chip_select_n && a_in.write_not_read && a_in.enable;
    assign a_sel_rd = !a_in.chip_select_n && !a_in.write_not_read && a_in.enable;
    assign b_sel_wr = !b_in.chip_select_n && b_in.write_not_read && b_in.enable;
    assign b_sel_rd = !b_in.chip_select_n && !b_in.write_not_read && b_in.enable;
    assign fifo_wr = a_edge && a_sel_wr && !a_in.mailbox_select && full_n;
    assign fifo_rd = b_edge && b_sel_rd && !b_in.mailbox_select && empty_n;
    assign a_mbox_wr = a_edge && a_sel_wr && a_in.mailbox_select && a_to_b_mailbox_flag_n;
    assign b_mbox_wr = b_edge && b_sel_wr && b_in.mailbox_select && b_to_a_mailbox_flag_n;
    assign a_mbox_rd = a_edge && a_sel_rd && a_in.mailbox_select;
    assign b_mbox_rd = b_edge && b_sel_rd && b_in.mailbox_select;
    assign a_gen_setup = a_sel_rd && a_in.mailbox_select && a_in.parity_gen_select;
    assign b_gen_setup = b_sel_rd && b_in.mailbox_select && b_in.parity_gen_select;

    // ----------------------------------------------------------------
    // Offset register and reset release
    // ----------------------------------------------------------------
    logic [2:0] load_wait;
    logic [4:0] offset_x;
    logic [1:0] a_ready;
    logic [1:0] b_ready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            load_wait <= 3'h0;
            offset_x <= fifo_mailbox_pkg::OFFSET_CODE_00;
        end else if (load_wait != fifo_mailbox_pkg::OFFSET_LOAD_WAIT) begin
            load_wait <= load_wait + 3'h1;
            if (load_wait == fifo_mailbox_pkg::OFFSET_LOAD_WAIT - 3'h1) begin
                case (offset_in)
                    2'h3: offset_x <= fifo_mailbox_pkg::OFFSET_CODE_11;
                    2'h2: offset_x <= fifo_mailbox_pkg::OFFSET_CODE_10;
                    2'h1: offset_x <= fifo_mailbox_pkg::OFFSET_CODE_01;
                    default: offset_x <= fifo_mailbox_pkg::OFFSET_CODE_00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_ready <= 2'h0;
            b_ready <= 2'h0;
        end else begin
            if (a_edge) begin
                a_ready <= {a_ready[0], 1'b1};
            end
            if (b_edge) begin
                b_ready <= {b_ready[0], 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------
    // Memory and pointers
    // ----------------------------------------------------------------
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW-1:0] next_wptr;
    logic [PW-1:0] next_rptr;
    logic [PW-1:0] wptr_gray;
    logic [PW-1:0] rptr_gray;
    logic [DW-1:0] fifo_out;

    assign next_wptr = fifo_wr ? PW'(wptr + 7'h01) : wptr;
    assign next_rptr = fifo_rd ? PW'(rptr + 7'h01) : rptr;

    always_ff @(posedge clk) begin
        if (fifo_wr) begin
            mem[wptr[AW-1:0]] <= a_in.data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wptr <= '0;
            rptr <= '0;
            wptr_gray <= '0;
            rptr_gray <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            wptr_gray <= fifo_mailbox_pkg::bin_to_gray(next_wptr);
            rptr_gray <= fifo_mailbox_pkg::bin_to_gray(next_rptr);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fifo_out <= '0;
        end else if (fifo_rd) begin
            fifo_out <= b_in.parity_gen_select ?
                fifo_mailbox_pkg::gen_parity(mem[rptr[AW-1:0]], b_in.odd_even) :
                mem[rptr[AW-1:0]];
        end
    end

    // ----------------------------------------------------------------
    // Port A flags: full and almost full
    // ----------------------------------------------------------------
    logic [PW-1:0] rptr_sync_a;
    logic [PW-1:0] fill_a;
    logic [PW-1:0] af_level;

    assign fill_a = PW'(next_wptr - fifo_mailbox_pkg::gray_to_bin(rptr_sync_a));
    assign af_level = PW'(fifo_mailbox_pkg::FIFO_DEPTH - {2'h0, offset_x});

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rptr_sync_a <= '0;
            full_n <= 1'b0;
            almost_full_n <= 1'b1;
        end else if (a_edge) begin
            rptr_sync_a <= rptr_gray;
            full_n <= a_ready[0] && (fill_a != fifo_mailbox_pkg::FIFO_DEPTH);
            almost_full_n <= fill_a < af_level;
        end
    end

    // ----------------------------------------------------------------
    // Port B flags: empty and almost empty
    // ----------------------------------------------------------------
    logic [PW-1:0] wptr_sync_b;
    logic [PW-1:0] fill_b;

    assign fill_b = PW'(fifo_mailbox_pkg::gray_to_bin(wptr_sync_b) - next_rptr);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wptr_sync_b <= '0;
            empty_n <= 1'b0;
            almost_empty_n <= 1'b0;
        end else if (b_edge) begin
            wptr_sync_b <= wptr_gray;
            empty_n <= b_ready[0] && (fill_b != '0);
            almost_empty_n <= fill_b > {2'h0, offset_x};
        end
    end

    // ----------------------------------------------------------------
    // Mailboxes
    // ----------------------------------------------------------------
    logic [DW-1:0] a_to_b_mailbox;
    logic [DW-1:0] b_to_a_mailbox;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_to_b_mailbox <= '0;
            a_to_b_mailbox_flag_n <= 1'b1;
        end else begin
            if (a_mbox_wr) begin
                a_to_b_mailbox <= a_in.data;
                a_to_b_mailbox_flag_n <= 1'b0;
            end else if (b_mbox_rd) begin
                a_to_b_mailbox_flag_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            b_to_a_mailbox <= '0;
            b_to_a_mailbox_flag_n <= 1'b1;
        end else begin
            if (b_mbox_wr) begin
                b_to_a_mailbox <= b_in.data;
                b_to_a_mailbox_flag_n <= 1'b0;
            end else if (a_mbox_rd) begin
                b_to_a_mailbox_flag_n <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Data outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_a_data_out <= '0;
            port_a_data_oe_n <= 1'b1;
            port_b_data_out <= '0;
            port_b_data_oe_n <= 1'b1;
        end else begin
            port_a_data_oe_n <= a_in.chip_select_n || a_in.write_not_read;
            port_b_data_oe_n <= b_in.chip_select_n || b_in.write_not_read;
            port_a_data_out <= a_in.parity_gen_select ?
                fifo_mailbox_pkg::gen_parity(b_to_a_mailbox, a_in.odd_even) : b_to_a_mailbox;
            if (!b_in.mailbox_select) begin
                port_b_data_out <= fifo_out;
            end else begin
                port_b_data_out <= b_in.parity_gen_select ?
                    fifo_mailbox_pkg::gen_parity(a_to_b_mailbox, b_in.odd_even) :
                    a_to_b_mailbox;
            end
        end
    end

    // ----------------------------------------------------------------
    // Parity checking
    // ----------------------------------------------------------------
    logic [fifo_mailbox_pkg::LANES-1:0] a_lane_err;
    logic [fifo_mailbox_pkg::LANES-1:0] b_lane_err;

    for (genvar l = 0; l < fifo_mailbox_pkg::LANES; l++) begin : g_lane
        localparam int LO = l * fifo_mailbox_pkg::LANE_W;
        assign a_lane_err[l] = (^a_in.data[LO +: fifo_mailbox_pkg::LANE_W]) != a_in.odd_even;
        assign b_lane_err[l] = (^b_in.data[LO +: fifo_mailbox_pkg::LANE_W]) != b_in.odd_even;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_a_parity_error_n <= 1'b1;
            port_b_parity_error_n <= 1'b1;
        end else begin
            port_a_parity_error_n <= a_gen_setup || !(|a_lane_err);
            port_b_parity_error_n <= b_gen_setup || !(|b_lane_err);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_full_blocks_write: assert property (
        !full_n && a_edge && a_sel_wr && !a_in.mailbox_select |=> wptr == $past(wptr))
        else $error("write taken while full");
    a_empty_blocks_read: assert property (
        !empty_n && b_edge |=> rptr == $past(rptr) && fifo_out == $past(fifo_out))
        else $error("read taken while empty");
    a_wptr_steps_one: assert property (
        fifo_wr |=> wptr == PW'($past(wptr) + 7'h01))
        else $error("write pointer did not step by one");
    a_rptr_steps_one: assert property (
        fifo_rd |=> rptr == PW'($past(rptr) + 7'h01)
            && (fifo_out == $past(mem[rptr[AW-1:0]]) || $past(b_in.parity_gen_select)))
        else $error("read pointer did not step by one");
    a_full_on_a_edge: assert property (
        $changed(full_n) || $changed(almost_full_n) |-> $past(a_edge))
        else $error("full flags moved off a port A edge");
    a_empty_on_b_edge: assert property (
        $changed(empty_n) || $changed(almost_empty_n) |-> $past(b_edge))
        else $error("empty flags moved off a port B edge");
    a_empty_true_fill: assert property (
        empty_n |-> wptr != rptr)
        else $error("empty flag high with no word stored");
    a_full_true_fill: assert property (
        full_n |-> PW'(wptr - rptr) != fifo_mailbox_pkg::FIFO_DEPTH)
        else $error("full flag high with memory full");
    a_mbox_store: assert property (
        a_mbox_wr |=> a_to_b_mailbox == $past(a_in.data) && !a_to_b_mailbox_flag_n)
        else $error("mailbox write not stored");
    a_mbox_hold: assert property (
        !b_to_a_mailbox_flag_n && !a_mbox_rd |=> b_to_a_mailbox == $past(b_to_a_mailbox)
            && !b_to_a_mailbox_flag_n)
        else $error("full mailbox changed");
    a_parity_forced: assert property (
        a_gen_setup |=> port_a_parity_error_n)
        else $error("parity error not held during generation");
    a_offset_legal: assert property (
        load_wait == fifo_mailbox_pkg::OFFSET_LOAD_WAIT |-> offset_x inside {5'h04, 5'h08,
            5'h0C, 5'h10})
        else $error("offset register holds an illegal value");

    c_fifo_full: cover property (!full_n && a_ready[1]);
    c_empty_rise: cover property (!empty_n ##1 empty_n);
    c_mbox_round: cover property (a_mbox_wr ##[1:200] b_mbox_rd);
    c_parity_err: cover property (!port_b_parity_error_n);

endmodule // fifo_mailbox
`default_nettype wire

//--- bench/port_master.sv
// Bus master model for one port: makes the port clock and drives one request per cycle.
// Assumes clk is the system clock; requests change just after a falling port clock edge.
`timescale 1ns/100ps
`default_nettype none
module port_master #(
    parameter int HALF = 8
) (
    input wire logic clk,
    output logic port_clock,
    output logic [4:0] ctl,
    output logic [fifo_mailbox_pkg::DATA_W-1:0] data
);
    initial begin
        port_clock = 1'b0;
        ctl = 5'h10;
        data = '0;
        forever begin
            repeat (HALF) @(negedge clk);
            port_clock = ~port_clock;
        end
    end
    // Sets chip select, direction, enable, mailbox select, parity generation and bus.
    task automatic op(input logic [4:0] c, input logic [fifo_mailbox_pkg::DATA_W-1:0] d);
        @(negedge port_clock);
        @(negedge clk);
        ctl = c;
        data = d;
    endtask
    // Releases the port; the bus then carries the inverse of its last word.
    task automatic idle();
        op(5'h10, ~data);
    endtask
endmodule // port_master
`default_nettype wire

//--- bench/fifo_mailbox_test.sv
// Self-checking bench of the mailbox FIFO.
// Assumes the port masters hold requests from falling to falling port clock edge.
`timescale 1ns/100ps
`default_nettype none
module fifo_mailbox_test;
    logic clk, nrst, odd_even, fs_lsb, fs_msb, run, b_rd;
    logic [4:0] a_ctl, b_ctl;
    logic [35:0] a_in, b_in, a_out, b_out, w, last;
    logic a_clk, b_clk, full_n, almost_full_n, empty_n, almost_empty_n, mf_ab, mf_ba, pe_a;
    logic pe_b, oe_a, oe_b, b_pg;
    logic [35:0] w_b;
    logic [31:0] seed = 32'h18;
    logic [35:0] exp_q[$];
    int n_errors = 0;
    int total_checks = 0;
    int x;
    port_master #(.HALF(8)) u_pa (.clk(clk), .port_clock(a_clk), .ctl(a_ctl), .data(a_in));
    port_master #(.HALF(9)) u_pb (.clk(clk), .port_clock(b_clk), .ctl(b_ctl), .data(b_in));
    fifo_mailbox u_dut (.clk(clk), .nrst(nrst), .port_a_clock(a_clk),
        .port_a_chip_select_n(a_ctl[4]), .port_a_write_not_read(a_ctl[3]),
        .port_a_enable(a_ctl[2]), .port_a_mailbox_select(a_ctl[1]),
        .port_a_parity_gen_select(a_ctl[0]), .port_a_data_in(a_in), .port_a_data_out(a_out),
        .port_a_data_oe_n(oe_a), .port_b_clock(b_clk), .port_b_chip_select_n(b_ctl[4]),
        .port_b_write_not_read(b_ctl[3]), .port_b_enable(b_ctl[2]),
        .port_b_mailbox_select(b_ctl[1]), .port_b_parity_gen_select(b_ctl[0]),
        .port_b_data_in(b_in), .port_b_data_out(b_out), .port_b_data_oe_n(oe_b),
        .odd_even(odd_even), .offset_select_lsb(fs_lsb), .offset_select_msb(fs_msb),
        .full_n(full_n), .almost_full_n(almost_full_n), .empty_n(empty_n),
        .almost_empty_n(almost_empty_n), .a_to_b_mailbox_flag_n(mf_ab),
        .b_to_a_mailbox_flag_n(mf_ba), .port_a_parity_error_n(pe_a),
        .port_b_parity_error_n(pe_b));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [35:0] gen(input logic [35:0] d);
        for (int l = 0; l < 4; l++) d[l*9+8] = ^d[l*9+:8] ^ odd_even;
        return d;
    endfunction
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rnd();
        seed = lfsr(seed);
        w = {seed[3:0], seed};
    endtask
    task automatic settle();
        repeat (100) @(negedge clk);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------
    // Watchers.
    // ----------------------------------------
    always @(posedge a_clk) begin
        if (run) begin
            repeat (7) @(negedge clk);
            check(36'(pe_a), 36'(a_ctl == 5'h07 || gen(a_in) == a_in));
            check(36'(oe_a), 36'(a_ctl[4] | a_ctl[3]));
        end
    end
    always @(posedge b_clk) begin
        if (run) begin
            repeat (7) @(negedge clk);
            check(36'(pe_b), 36'(b_ctl == 5'h07 || gen(b_in) == b_in));
            check(36'(oe_b), 36'(b_ctl[4] | b_ctl[3]));
        end
    end
    always @(posedge b_clk) begin
        b_rd = b_ctl[4:1] == 4'h2 && empty_n === 1'b1;
        b_pg = b_ctl[0];
        @(negedge b_clk);
        if (b_rd) begin
            w_b = exp_q.size() > 0 ? exp_q.pop_front() : ~b_out;
            check(b_out, b_pg ? gen(w_b) : w_b);
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        results();
    end
    // ----------------------------------------
    // Main sequence.
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        run = 1'b0;
        seed = lfsr(seed);
        odd_even = seed[0];
        {fs_msb, fs_lsb} = seed[2:1];
        x = 4 + 4 * seed[2:1];
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        check(36'({full_n, empty_n, almost_empty_n, almost_full_n, mf_ab, mf_ba}), 36'h07);
        settle();
        check(36'(full_n), 36'h1);
        run = 1'b1;
        for (int i = 0; i < 65; i++) begin
            if (i == x || i == x + 1 || i == 63 - x || i == 64 - x) begin
                u_pa.idle();
                settle();
                check(36'({almost_empty_n, almost_full_n}), 36'({i > x, i < 64 - x}));
            end
            rnd();
            u_pa.op(5'h0C, w);
            if (i < 64) exp_q.push_back(w);
            if (i < 64) last = w;
        end
        u_pa.idle();
        settle();
        check(36'({full_n, empty_n}), 36'h1);
        u_pb.op(5'h05, 36'h0);
        u_pb.idle();
        settle();
        check(36'({full_n, almost_full_n}), 36'h2);
        repeat (64) u_pb.op(5'h04, 36'h0);
        u_pb.idle();
        settle();
        check(36'({empty_n, almost_empty_n, exp_q.size()}), 36'h0);
        check(b_out, last);
        rnd();
        last = w;
        u_pa.op(5'h0E, w);
        rnd();
        u_pa.op(5'h0E, w);
        u_pa.idle();
        settle();
        check(36'(mf_ab), 36'h0);
        u_pb.op(5'h06, 36'h0);
        u_pb.idle();
        check(b_out, last);
        settle();
        check(36'(mf_ab), 36'h1);
        rnd();
        last = w;
        u_pb.op(5'h0E, w);
        u_pb.idle();
        settle();
        check(36'(mf_ba), 36'h0);
        u_pa.op(5'h07, 36'h0);
        u_pa.idle();
        check(a_out, gen(last));
        settle();
        check(36'(mf_ba), 36'h1);
        results();
    end
endmodule // fifo_mailbox_test
`default_nettype wire
